// ===== logic/bst_pkg.sv
// Behaviour
// - inputs sampled on test clock rising edge
// - data out changes on falling edge only
// - data in enters selected register MSB
// - data out shows selected register LSB
// - data out driven only in shift states
// - instruction picks the single scan path
// - five high mode-selects reset, memory untouched
// - power-up reset leaves data out undriven
// - instruction updates in Update-IR, preload identification
// - capture-IR loads 01 into low bits
// - one-bit bypass, cleared on capture
// - 113-bit boundary register captures and shifts
// - calibration pin testable only with bit zero
// - idle test clock holds controller state and outputs, except the calibration bit, which follows mode writes
// - mandatory and optional instruction set supported
// - eight-bit instruction register, others reserved
// - fixed 32-bit identification captured and shifted
// - high-impedance instruction selects bypass, floats outputs
package bst_pkg;
  localparam int unsigned IR_W        = 8;
  localparam int unsigned BSR_W       = 113;
  localparam int unsigned ID_W        = 32;
  localparam logic [1:0]  IR_CAPTURE  = 2'h1;
  localparam logic [5:0]  IR_CAP_HIGH = 6'h00;
  // instruction codes; values are arbitrary
  localparam logic [7:0]  INS_EXTEST   = 8'h00;
  localparam logic [7:0]  INS_SAMPLE   = 8'h01;
  localparam logic [7:0]  INS_PRELOAD  = 8'h02;
  localparam logic [7:0]  INS_CLAMP    = 8'h03;
  localparam logic [7:0]  INS_HIGHZ    = 8'h04;
  localparam logic [7:0]  INS_IDCODE   = 8'h05;
  localparam logic [7:0]  INS_ECIDCODE = 8'h06;
  localparam logic [7:0]  INS_BYPASS   = 8'hFF;
  // identification codes; values are arbitrary
  localparam logic [31:0] ID_CODE     = 32'h0000_0001;
  localparam logic [31:0] ECID_CODE   = 32'h0000_0003;
  localparam int unsigned CAL_PIN_IDX = 0;

  typedef enum logic [15:0] {
    ST_RESET  = 16'h0001,
    ST_IDLE   = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR  = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UP_DR  = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR  = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UP_IR  = 16'h8000
  } bst_state_t;
endpackage : bst_pkg

// ===== logic/bst_tap.sv
module bst_tap #(
  parameter int unsigned BSR_W   = bst_pkg::BSR_W,
  parameter int unsigned CAL_IDX = bst_pkg::CAL_PIN_IDX
) (
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             ce_in,
  input  wire logic             tck_in,
  input  wire logic             tms_in,
  input  wire logic             tdi_in,
  input  wire logic [BSR_W-1:0] pin_ring_in,
  input  wire logic             mode_wr_in,
  input  wire logic             mode_cal_bit_in,
  output logic                  tdo_out,
  output logic                  tdo_oe_out,
  output logic [BSR_W-1:0]      bsr_drive_out,
  output logic                  bsr_drive_en_out,
  output logic                  mem_hiz_out,
  output logic                  cal_pin_test_bit_out
);
  import bst_pkg::*;

  typedef struct packed {
    logic             tck_s1;
    logic             tck_s2;
    logic             tck_s3;
    logic             tms_s1;
    logic             tms_s2;
    logic             tdi_s1;
    logic             tdi_s2;
    logic [BSR_W-1:0] ring_s1;
    logic [BSR_W-1:0] ring_s2;
    bst_state_t       state;
    logic [IR_W-1:0]  ir;
    logic [IR_W-1:0]  ir_sh;
    logic             byp;
    logic [ID_W-1:0]  id_sh;
    logic [BSR_W-1:0] bsr_sh;
    logic [BSR_W-1:0] bsr_upd;
    logic             cal_bit;
    logic             tdo;
    logic             tdo_oe;
    logic             drive_en;
    logic             hiz;
  } bst_regs_t;

  bst_regs_t s_r;
  bst_regs_t s_nxt;

  function automatic bst_state_t tap_next(input bst_state_t st, input logic tms);
    case (st)
      ST_RESET:  tap_next = tms ? ST_RESET  : ST_IDLE;
      ST_IDLE:   tap_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  tap_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = tms ? ST_UP_DR  : ST_PA_DR;
      ST_PA_DR:  tap_next = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: tap_next = tms ? ST_UP_DR  : ST_SH_DR;
      ST_UP_DR:  tap_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = tms ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  tap_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = tms ? ST_UP_IR  : ST_PA_IR;
      ST_PA_IR:  tap_next = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: tap_next = tms ? ST_UP_IR  : ST_SH_IR;
      ST_UP_IR:  tap_next = tms ? ST_SEL_DR : ST_IDLE;
      default:   tap_next = ST_RESET;
    endcase
  endfunction : tap_next

  logic tck_rise;
  logic tck_fall;
  logic sel_bsr;
  logic sel_id;
  logic dr_lsb;

  always_comb begin
    tck_rise = s_r.tck_s2 & ~s_r.tck_s3;
    tck_fall = ~s_r.tck_s2 & s_r.tck_s3;
    // reserved codes fall back to bypass so the chain length stays defined
    sel_bsr  = (s_r.ir == INS_EXTEST) || (s_r.ir == INS_SAMPLE) || (s_r.ir == INS_PRELOAD);
    sel_id   = (s_r.ir == INS_IDCODE) || (s_r.ir == INS_ECIDCODE);
    dr_lsb   = sel_bsr ? s_r.bsr_sh[0] : (sel_id ? s_r.id_sh[0] : s_r.byp);

    s_nxt         = s_r;
    s_nxt.tck_s1  = tck_in;
    s_nxt.tck_s2  = s_r.tck_s1;
    s_nxt.tck_s3  = s_r.tck_s2;
    s_nxt.tms_s1  = tms_in;
    s_nxt.tms_s2  = s_r.tms_s1;
    s_nxt.tdi_s1  = tdi_in;
    s_nxt.tdi_s2  = s_r.tdi_s1;
    s_nxt.ring_s1 = pin_ring_in;
    s_nxt.ring_s2 = s_r.ring_s1;

    // mode-register copy lives in the memory clock domain, untouched by the test reset
    if (mode_wr_in) begin
      s_nxt.cal_bit = mode_cal_bit_in;
    end

    if (tck_rise) begin
      s_nxt.state = tap_next(s_r.state, s_r.tms_s2);
      case (s_r.state)
        ST_RESET: begin
          s_nxt.ir = INS_IDCODE;
        end
        ST_CAP_IR: begin
          s_nxt.ir_sh = {IR_CAP_HIGH, IR_CAPTURE};
        end
        ST_SH_IR: begin
          s_nxt.ir_sh = {s_r.tdi_s2, s_r.ir_sh[IR_W-1:1]};
        end
        ST_UP_IR: begin
          s_nxt.ir = s_r.ir_sh;
        end
        ST_CAP_DR: begin
          if (sel_bsr) begin
            s_nxt.bsr_sh = s_r.ring_s2;
            // a set calibration bit makes that cell meaningless, so it reads as zero
            if (s_r.cal_bit) begin
              s_nxt.bsr_sh[CAL_IDX] = 1'b0;
            end
          end else if (sel_id) begin
            s_nxt.id_sh = (s_r.ir == INS_ECIDCODE) ? ECID_CODE : ID_CODE;
          end else begin
            s_nxt.byp = 1'b0;
          end
        end
        ST_SH_DR: begin
          if (sel_bsr) begin
            s_nxt.bsr_sh = {s_r.tdi_s2, s_r.bsr_sh[BSR_W-1:1]};
          end else if (sel_id) begin
            s_nxt.id_sh = {s_r.tdi_s2, s_r.id_sh[ID_W-1:1]};
          end else begin
            s_nxt.byp = s_r.tdi_s2;
          end
        end
        ST_UP_DR: begin
          if (sel_bsr) begin
            s_nxt.bsr_upd = s_r.bsr_sh;
          end
        end
        default: begin
        end
      endcase
    end

    // output controls follow the instruction in force, falling edge keeps them aligned to tdo
    if (tck_fall) begin
      s_nxt.tdo      = (s_r.state == ST_SH_IR) ? s_r.ir_sh[0] : dr_lsb;
      s_nxt.tdo_oe   = (s_r.state == ST_SH_IR) || (s_r.state == ST_SH_DR);
      s_nxt.drive_en = (s_r.ir == INS_EXTEST) || (s_r.ir == INS_CLAMP);
      s_nxt.hiz      = (s_r.ir == INS_HIGHZ);
    end
  end

  // power-up reset parks the controller in reset with the output floating
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_r          <= '0;
      s_r.state    <= ST_RESET;
      s_r.ir       <= INS_IDCODE;
      s_r.tdo_oe   <= 1'b0;
      s_r.cal_bit  <= 1'b0;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    tdo_out              = s_r.tdo;
    tdo_oe_out           = s_r.tdo_oe;
    bsr_drive_out        = s_r.bsr_upd;
    bsr_drive_en_out     = s_r.drive_en;
    mem_hiz_out          = s_r.hiz;
    cal_pin_test_bit_out = s_r.cal_bit;
  end
endmodule : bst_tap

// ===== tb/boundary_scan_tap_tb.sv
module boundary_scan_tap_tb;
  import bst_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, arst_n_in, ce_in, tck_in, tms_in, tdi_in, mode_wr_in, mode_cal_bit_in;
  logic tdo_out, tdo_oe_out, bsr_drive_en_out, mem_hiz_out, cal_pin_test_bit_out;
  logic [BSR_W-1:0] pin_ring_in, bsr_drive_out, v;
  int errors = 0;
  int check_count = 0;
  // bit 0 is set so that a masked calibration cell shows up in the capture
  localparam logic [BSR_W-1:0] P1 = {1'b1, {4{28'hA5C396F}}};
  bst_tap u_dut (.*);
  bst_tap_ctl u_ctl (.clk_in, .tdo_in(tdo_out), .tdo_oe_in(tdo_oe_out),
                     .tck_out(tck_in), .tms_out(tms_in), .tdi_out(tdi_in));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    #400000;
    errors++;
    wrap_up();
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic cmp(input logic [BSR_W-1:0] got, input logic [BSR_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  // idle first, then header, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [BSR_W-1:0] din, output logic [BSR_W-1:0] dout);
    logic o;
    dout = '0;
    u_ctl.step(1'b0, 1'b1, o);
    u_ctl.step(1'b1, 1'b1, o);
    if (ir) u_ctl.step(1'b1, 1'b1, o);
    u_ctl.step(1'b0, 1'b1, o);
    u_ctl.step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      u_ctl.step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    u_ctl.step(1'b1, 1'b1, o);
    u_ctl.step(1'b0, 1'b1, o);
    u_ctl.step(1'b0, 1'b1, o);
    u_ctl.park();
  endtask : scan
  task automatic t_ids();
    cmp(BSR_W'(tdo_oe_out), '0);
    scan(1'b0, 32, '0, v);
    cmp(v, BSR_W'(ID_CODE));
    scan(1'b1, 8, BSR_W'(INS_ECIDCODE), v);
    cmp(v, BSR_W'(8'h01));
    scan(1'b0, 32, '0, v);
    cmp(v, BSR_W'(ECID_CODE));
    $display("t_ids done");
  endtask : t_ids
  task automatic t_boundary();
    scan(1'b1, 8, BSR_W'(INS_SAMPLE), v);
    scan(1'b0, BSR_W, '0, v);
    cmp(v, P1);
    scan(1'b1, 8, BSR_W'(INS_PRELOAD), v);
    scan(1'b0, BSR_W, ~P1, v);
    scan(1'b1, 8, BSR_W'(INS_EXTEST), v);
    cmp({bsr_drive_out[BSR_W-2:0], bsr_drive_en_out}, {~P1[BSR_W-2:0], 1'b1});
    $display("t_boundary done");
  endtask : t_boundary
  task automatic t_paths();
    logic [7:0] c [4];
    c = '{INS_CLAMP, INS_BYPASS, 8'h80, INS_HIGHZ};
    for (int i = 0; i < 4; i++) begin
      scan(1'b1, 8, BSR_W'(c[i]), v);
      cmp(BSR_W'({mem_hiz_out, bsr_drive_en_out}), BSR_W'({c[i] == INS_HIGHZ, c[i] == INS_CLAMP}));
      scan(1'b0, 2, '1, v);
      cmp(v, BSR_W'(2'b10));
      cmp(BSR_W'(tdo_oe_out), '0);
    end
    $display("t_paths done");
  endtask : t_paths
  task automatic t_reset();
    logic o;
    @(posedge clk_in);
    mode_wr_in <= 1'b1;
    mode_cal_bit_in <= 1'b1;
    @(posedge clk_in);
    mode_wr_in <= 1'b0;
    ce_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    ce_in <= 1'b1;
    for (int i = 0; i < 5; i++) u_ctl.step(1'b1, 1'b1, o);
    scan(1'b0, 32, '0, v);
    cmp(v, BSR_W'(ID_CODE));
    cmp(BSR_W'({mem_hiz_out, cal_pin_test_bit_out}), BSR_W'(2'b01));
    scan(1'b1, 8, BSR_W'(INS_SAMPLE), v);
    scan(1'b0, BSR_W, '0, v);
    cmp(v, P1 & ~BSR_W'(1));
    $display("t_reset done");
  endtask : t_reset
  initial begin
    arst_n_in = 1'b0;
    ce_in = 1'b1;
    mode_wr_in = 1'b0;
    mode_cal_bit_in = 1'b0;
    pin_ring_in = P1;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_ids();
    t_boundary();
    t_paths();
    t_reset();
    wrap_up();
  end
endmodule : boundary_scan_tap_tb

// ===== tb/bst_tap_ctl.sv
module bst_tap_ctl (
  input  wire logic clk_in,
  input  wire logic tdo_in,
  input  wire logic tdo_oe_in,
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_r;
  logic seen;
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  always_ff @(posedge clk_in) if (tdo_oe_in) last_r <= tdo_in;
  // undriven line has no pull: inverse of last bit so a float never reads as data
  assign seen = tdo_oe_in ? tdo_in : ~last_r;
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge clk_in);
    tck_out <= 1'b0;
    tms_out <= m;
    tdi_out <= d;
    repeat (4) @(posedge clk_in);
    tck_out <= 1'b1;
    @(negedge clk_in);
    o = seen;
    repeat (3) @(posedge clk_in);
  endtask : step
  task automatic park();
    @(posedge clk_in);
    tck_out <= 1'b0;
    tms_out <= 1'b1;
    tdi_out <= 1'b1;
    repeat (20) @(posedge clk_in);
  endtask : park
endmodule : bst_tap_ctl

// ===== tb/bst_tap_properties.sv
module bst_tap_props (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic tck_in,
  input wire logic mode_wr_in,
  input wire logic mode_cal_bit_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_out,
  input wire logic bsr_drive_en_out,
  input wire logic mem_hiz_out,
  input wire logic cal_pin_test_bit_out
);
  logic [3:0] low_r;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  // saturating count of system clock cycles with the test clock held low
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) low_r <= 4'h0;
    else if (tck_in) low_r <= 4'h0;
    else if (low_r != 4'hF) low_r <= low_r + 4'h1;
  end
  a_tdo_fall: assert property ($changed(tdo_out) |-> !$past(tck_in) && !$past(tck_in, 2))
    else $error("tdo moved off a clock fall");
  a_oe_fall: assert property ($changed(tdo_oe_out) |-> !$past(tck_in) && !$past(tck_in, 2))
    else $error("tdo enable moved off a clock fall");
  a_drive_fall: assert property ($changed(bsr_drive_en_out) |-> !$past(tck_in) && !$past(tck_in, 2))
    else $error("drive enable moved off a clock fall");
  a_hiz_fall: assert property ($changed(mem_hiz_out) |-> !$past(tck_in) && !$past(tck_in, 2))
    else $error("float control moved off a clock fall");
  a_cal_write: assert property (mode_wr_in |=> cal_pin_test_bit_out == $past(mode_cal_bit_in))
    else $error("calibration bit not written");
  a_cal_hold: assert property (!mode_wr_in |=> $stable(cal_pin_test_bit_out))
    else $error("calibration bit moved without a write");
  a_park_quiet: assert property (low_r == 4'hF |-> $stable(tdo_oe_out) && $stable(mem_hiz_out))
    else $error("parked test clock changed outputs");
  a_ce_hold: assert property (!ce_in |=> $stable(tdo_out) && $stable(tdo_oe_out))
    else $error("outputs moved while halted");
  cover property (mode_wr_in);
  cover property ($rose(mem_hiz_out));
  cover property ($rose(bsr_drive_en_out));
endmodule : bst_tap_props
bind bst_tap bst_tap_props u_props (.*);
